//--- rtl/texel_params.svh
// Purpose: Offsets, field positions, reset values and timing counts for the texel decoder.
// Assumes: Included by its bare name from every design file that needs it.
// Notes:   Definitions only.
`ifndef TEXEL_PARAMS_SVH
`define TEXEL_PARAMS_SVH

// ****************************************************************
// Control word fields
// ****************************************************************
`define PIXFMT_MSB      29
`define PIXFMT_LSB      27
`define PALSEL_MSB      26
`define PALSEL_LSB      21
`define PALSEL8_LSB     25

// ****************************************************************
// Register map, byte addresses
// ****************************************************************
`define OFS_PALFMT      13'h0000
`define OFS_FILTER      13'h0004
`define OFS_COUNT       13'h0008
`define PAL_WIN_BIT     12

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define RST_PALFMT      2'h0
`define RST_FILTER      1'h0
`define ALPHA_OPAQUE    8'hFF
`define BUMP_FULL_CODE  8'hFF
`define BUMP_FULL_VAL   9'h100
`define PAL_LATENCY     2

`endif

//--- rtl/texel_pkg.sv
// Purpose: Types shared by the texel decoder files.
// Assumes: Nothing.
// Notes:   Enumeration order is the field encoding.
`default_nettype none
package texel_pkg;
    // Pixel format field of the per-texture control word.
    typedef enum logic [2:0] {
        FMT_1555, FMT_565, FMT_4444, FMT_YUV, FMT_BUMP,
        FMT_FOUR_BIT_INDEX, FMT_EIGHT_BIT_INDEX, FMT_ILLEGAL
    } pix_fmt_t;
    // Palette entry format held by the palette entry format register.
    typedef enum logic [1:0] {
        PAL_1555, PAL_565, PAL_4444, PAL_8888
    } pal_fmt_t;
endpackage
`default_nettype wire

//--- rtl/pal_port_if.sv
// Purpose: Write and read port bundle between the decoder and palette memory.
// Assumes: One clock; read data returns one edge after the read request.
// Notes:   ctrl is the decoder side, mem the memory side.
`default_nettype none
interface pal_port_if #(parameter int AW = 10, parameter int DW = 32);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic          rd_en;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;
    modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
    modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface
`default_nettype wire

//--- rtl/palette_ram.sv
// Purpose: Palette color memory with one write and one registered read port.
// Assumes: Caller keeps addresses inside DEPTH.
// Notes:   Contents are undefined until software loads them.
`default_nettype none
module palette_ram #(
    parameter int DEPTH = 1024
) (
    input  wire logic clk,
    pal_port_if.mem   port
);
    logic [31:0] mem_q [DEPTH];

    // ****************************************************************
    // Storage
    // ****************************************************************
    // Software writes land in the array.
    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            mem_q[port.wr_addr] <= port.wr_data;
        end
    end

    // Read data comes out of a register, held while no read is asked.
    always_ff @(posedge clk) begin
        if (port.rd_en) begin
            port.rd_data <= mem_q[port.rd_addr];
        end
    end
endmodule
`default_nettype wire

//--- rtl/texel_format_decoder.sv
// Purpose: Decodes texels (RGB, YUV, bump map, palette index) into ARGB8888 and bump angles.
// Assumes: Fetch logic and shading pipeline share CLOCK; output has no back-pressure.
// Notes:   Two-edge latency from acceptance to OUT_VALID for every format.
//
// Operation
// - Pixel format field of control word picks how each texel is decoded.
// - RGB1555 texel: alpha bit 15, red 14-10, green 9-5, blue 4-0.
// - RGB565 texel: red 15-11, green 10-5, blue 4-0, no alpha.
// - RGB4444 texel: alpha 15-12, red 11-8, green 7-4, blue 3-0.
// - YUV item: low word left luma and U, high word right luma and V.
// - Every luma and chroma value is unsigned 8-bit, 0 to 255.
// - YUV converts to RGB with the 11/8 scaled chroma equations.
// - Converted RGB saturates to 0..255; YUV alpha is 255.
// - Bump texel: elevation in bits 15-8, azimuth in bits 7-0.
// - Each bump angle is code over 256 of 90 or 360 degrees.
// - Bump code 255 is replaced by 256 to reach the full angle.
// - Four-bit index: address is selector bits 26-21 then texel bits 3-0.
// - Eight-bit index: address is control bits 26-25 then texel bits 7-0.
// - Palette memory holds 1024 entries at a 10-bit address.
// - One palette entry format, from a register, covers all entries.
// - Palette 1555 entry: alpha bit 15, red 14-10, green 9-5, blue 4-0.
// - Palette 565 entry: red 15-11, green 10-5, blue 4-0, no alpha.
// - Palette 4444 entry: alpha 15-12, red 11-8, green 7-4, blue 3-0.
// - Palette 8888 entry: alpha 31-24, red 23-16, green 15-8, blue 7-0.
// - 8888 palette with non-point filtering accepts texels at half rate.
`include "texel_params.svh"
`default_nettype none
module texel_format_decoder #(
    parameter int PAL_DEPTH = 1024,
    parameter int PAL_AW    = 10
) (
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [12:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        IN_VALID,
    output logic             IN_READY,
    input  wire logic [31:0] IN_CTRL,
    input  wire logic [31:0] IN_DATA,
    output logic             OUT_VALID,
    output logic      [31:0] OUT_ARGB,
    output logic      [31:0] OUT_ARGB_RIGHT,
    output logic             OUT_PAIR,
    output logic             OUT_BUMP,
    output logic       [8:0] OUT_ELEV,
    output logic       [8:0] OUT_AZIM
);
    import texel_pkg::*;

    pal_port_if #(.AW(PAL_AW), .DW(32)) pal ();

    palette_ram #(.DEPTH(PAL_DEPTH)) u_palette (
        .clk  (CLOCK),
        .port (pal.mem)
    );

    logic        pready_q, pslverr_q, in_ready_q, filter_q, a_valid_q, out_valid_q;
    logic        out_pair_q, out_bump_q;
    logic [31:0] prdata_q, count_q, a_data_q, out_argb_q, out_right_q;
    logic [8:0]  out_elev_q, out_azim_q;
    pal_fmt_t    palfmt_q;
    pix_fmt_t    a_fmt_q, in_fmt;
    logic        accept, apb_done, half_rate, pal_win, reg_hit;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    // Widens a 16-bit color word of the given layout to ARGB8888 by bit replication.
    function automatic logic [31:0] dec16(input logic [15:0] w, input pal_fmt_t k);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (k)
            PAL_1555: r = {{8{w[15]}}, w[14:10], w[14:12], w[9:5], w[9:7], w[4:0], w[4:2]};
            PAL_565:  r = {`ALPHA_OPAQUE, w[15:11], w[15:13], w[10:5], w[10:9], w[4:0], w[4:2]};
            PAL_4444: r = {w[15:12], w[15:12], w[11:8], w[11:8], w[7:4], w[7:4], w[3:0], w[3:0]};
            PAL_8888: r = {`ALPHA_OPAQUE, w[15:8], w[15:8], w[15:8]};
        endcase
        return r;
    endfunction

    // Saturates a signed intermediate to an 8-bit channel.
    function automatic logic [7:0] clamp8(input logic signed [15:0] v);
        logic [7:0] r;
        r = v[7:0];
        if (v < 16'sd0) begin
            r = 8'h00;
        end else if (v > 16'sd255) begin
            r = 8'hFF;
        end
        return r;
    endfunction

    // Converts one luma with the shared chroma pair; shifts floor toward minus infinity.
    function automatic logic [31:0] yuv2rgb(input logic [7:0] y, input logic [7:0] u, input logic [7:0] v);
        logic signed [15:0] yy, du, dv, mu, mv, rr, gg, bb;
        yy = signed'({8'h00, y});
        du = signed'({8'h00, u}) - 16'sd128;
        dv = signed'({8'h00, v}) - 16'sd128;
        mu = du * 16'sd11;
        mv = dv * 16'sd11;
        rr = yy + (mv >>> 3);
        gg = yy - (mu >>> 5) - (mv >>> 4);
        bb = yy + ((du * 16'sd55) >>> 5);
        return {`ALPHA_OPAQUE, clamp8(rr), clamp8(gg), clamp8(bb)};
    endfunction

    // Replaces the top code by the full-range value.
    function automatic logic [8:0] bump_angle(input logic [7:0] c);
        return (c == `BUMP_FULL_CODE) ? `BUMP_FULL_VAL : {1'b0, c};
    endfunction

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Address decode and completion strobe.
    assign apb_done = PSEL & PENABLE & pready_q;
    assign pal_win  = PADDR[`PAL_WIN_BIT] & (PADDR[1:0] == 2'h0);
    assign reg_hit  = (PADDR == `OFS_PALFMT) | (PADDR == `OFS_FILTER) | (PADDR == `OFS_COUNT);

    // One wait cycle per access; read data and error are captured with pready.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= PSEL & PENABLE & ~pready_q;
            pslverr_q <= PSEL & PENABLE & ~pready_q & ~(reg_hit | pal_win);
            prdata_q  <= 32'h0000_0000;
            if (PSEL & PENABLE & ~pready_q & ~PWRITE) begin
                unique case (PADDR)
                    `OFS_PALFMT: prdata_q <= {30'h0000_0000, palfmt_q};
                    `OFS_FILTER: prdata_q <= {31'h0000_0000, filter_q};
                    `OFS_COUNT:  prdata_q <= count_q;
                    default:     prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Palette entry format register, one setting for every entry.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            palfmt_q <= pal_fmt_t'(`RST_PALFMT);
        end else if (apb_done & PWRITE & (PADDR == `OFS_PALFMT)) begin
            palfmt_q <= pal_fmt_t'(PWDATA[1:0]);
        end
    end

    // Filter mode register; set means any mode other than point sampling.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            filter_q <= `RST_FILTER;
        end else if (apb_done & PWRITE & (PADDR == `OFS_FILTER)) begin
            filter_q <= PWDATA[0];
        end
    end

    // Palette loads go straight into the memory write port.
    assign pal.wr_en   = apb_done & PWRITE & pal_win;
    assign pal.wr_addr = PADDR[PAL_AW+1:2];
    assign pal.wr_data = PWDATA;

    // ****************************************************************
    // Input acceptance
    // ****************************************************************
    // Format field of the control word and the acceptance strobe.
    assign in_fmt    = pix_fmt_t'(IN_CTRL[`PIXFMT_MSB:`PIXFMT_LSB]);
    assign accept    = IN_VALID & in_ready_q;
    assign half_rate = filter_q & (palfmt_q == PAL_8888);

    // Ready drops for one cycle after each accepted texel in half-rate mode.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            in_ready_q <= 1'b0;
        end else begin
            in_ready_q <= ~(half_rate & accept);
        end
    end

    // Palette address from selector and index; read is issued on acceptance.
    always_comb begin
        pal.rd_en   = 1'b0;
        pal.rd_addr = {IN_CTRL[`PALSEL_MSB:`PALSEL_LSB], IN_DATA[3:0]};
        if (accept & (in_fmt == FMT_FOUR_BIT_INDEX)) begin
            pal.rd_en = 1'b1;
        end else if (accept & (in_fmt == FMT_EIGHT_BIT_INDEX)) begin
            pal.rd_en   = 1'b1;
            pal.rd_addr = {IN_CTRL[`PALSEL_MSB:`PALSEL8_LSB], IN_DATA[7:0]};
        end
    end

    // First stage holds the texel while the palette read completes.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            a_valid_q <= 1'b0;
            a_fmt_q   <= FMT_1555;
            a_data_q  <= 32'h0000_0000;
        end else begin
            a_valid_q <= accept;
            if (accept) begin
                a_fmt_q  <= in_fmt;
                a_data_q <= IN_DATA;
            end
        end
    end

    // ****************************************************************
    // Output stage
    // ****************************************************************
    // Decodes the held texel into the output registers.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            out_valid_q <= 1'b0;
            out_argb_q  <= 32'h0000_0000;
            out_right_q <= 32'h0000_0000;
            out_pair_q  <= 1'b0;
            out_bump_q  <= 1'b0;
            out_elev_q  <= 9'h000;
            out_azim_q  <= 9'h000;
        end else begin
            out_valid_q <= a_valid_q;
            if (a_valid_q) begin
                out_pair_q  <= 1'b0;
                out_bump_q  <= 1'b0;
                out_right_q <= 32'h0000_0000;
                out_elev_q  <= 9'h000;
                out_azim_q  <= 9'h000;
                unique case (a_fmt_q)
                    FMT_1555: out_argb_q <= dec16(a_data_q[15:0], PAL_1555);
                    FMT_565:  out_argb_q <= dec16(a_data_q[15:0], PAL_565);
                    FMT_4444: out_argb_q <= dec16(a_data_q[15:0], PAL_4444);
                    FMT_YUV: begin
                        out_argb_q  <= yuv2rgb(a_data_q[15:8], a_data_q[7:0], a_data_q[23:16]);
                        out_right_q <= yuv2rgb(a_data_q[31:24], a_data_q[7:0], a_data_q[23:16]);
                        out_pair_q  <= 1'b1;
                    end
                    FMT_BUMP: begin
                        out_argb_q <= 32'h0000_0000;
                        out_bump_q <= 1'b1;
                        out_elev_q <= bump_angle(a_data_q[15:8]);
                        out_azim_q <= bump_angle(a_data_q[7:0]);
                    end
                    FMT_FOUR_BIT_INDEX, FMT_EIGHT_BIT_INDEX: begin
                        out_argb_q <= (palfmt_q == PAL_8888) ? pal.rd_data
                                                             : dec16(pal.rd_data[15:0], palfmt_q);
                    end
                    default: out_argb_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Counts decoded outputs for software.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            count_q <= 32'h0000_0000;
        end else if (a_valid_q) begin
            count_q <= count_q + 32'h0000_0001;
        end
    end

    // Ports straight from registers.
    assign PRDATA         = prdata_q;
    assign PREADY         = pready_q;
    assign PSLVERR        = pslverr_q;
    assign IN_READY       = in_ready_q;
    assign OUT_VALID      = out_valid_q;
    assign OUT_ARGB       = out_argb_q;
    assign OUT_ARGB_RIGHT = out_right_q;
    assign OUT_PAIR       = out_pair_q;
    assign OUT_BUMP       = out_bump_q;
    assign OUT_ELEV       = out_elev_q;
    assign OUT_AZIM       = out_azim_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    // Every accepted texel appears two edges later.
    chk_out_latency: assert property (accept |-> ##2 OUT_VALID)
        else $error("decoded texel did not appear two cycles after acceptance");
    chk_rgb1555_fields: assert property (a_valid_q && a_fmt_q == FMT_1555 |=>
        OUT_ARGB[23:19] == $past(a_data_q[14:10]) && OUT_ARGB[31] == $past(a_data_q[15]))
        else $error("1555 texel fields misplaced");
    chk_rgb565_opaque: assert property (a_valid_q && a_fmt_q == FMT_565 |=>
        OUT_ARGB[31:24] == 8'hFF && OUT_ARGB[15:10] == $past(a_data_q[10:5]))
        else $error("565 texel not opaque or green misplaced");
    chk_rgb4444_fields: assert property (a_valid_q && a_fmt_q == FMT_4444 |=>
        OUT_ARGB[31:28] == $past(a_data_q[15:12]) && OUT_ARGB[3:0] == $past(a_data_q[3:0]))
        else $error("4444 texel fields misplaced");
    chk_yuv_alpha: assert property (OUT_VALID && OUT_PAIR |->
        OUT_ARGB[31:24] == 8'hFF && OUT_ARGB_RIGHT[31:24] == 8'hFF)
        else $error("YUV texel alpha not full");
    chk_yuv_gray: assert property (a_valid_q && a_fmt_q == FMT_YUV && a_data_q[7:0] == 8'h80
        && a_data_q[23:16] == 8'h80 |=> OUT_ARGB[23:16] == $past(a_data_q[15:8]))
        else $error("neutral chroma did not pass luma through");
    chk_bump_full: assert property (a_valid_q && a_fmt_q == FMT_BUMP && a_data_q[15:8] == 8'hFF
        |=> OUT_ELEV == 9'h100 && OUT_BUMP)
        else $error("bump code 255 not replaced by 256");
    chk_pal4_addr: assert property (accept && in_fmt == FMT_FOUR_BIT_INDEX |-> pal.rd_en
        && pal.rd_addr == {IN_CTRL[26:21], IN_DATA[3:0]})
        else $error("four-bit palette address wrong");
    chk_pal8_addr: assert property (accept && in_fmt == FMT_EIGHT_BIT_INDEX |-> pal.rd_en
        && pal.rd_addr == {IN_CTRL[26:25], IN_DATA[7:0]})
        else $error("eight-bit palette address wrong");
    chk_pal8888_pass: assert property (a_valid_q && palfmt_q == PAL_8888 &&
        (a_fmt_q == FMT_FOUR_BIT_INDEX || a_fmt_q == FMT_EIGHT_BIT_INDEX) |=> OUT_ARGB == $past(pal.rd_data))
        else $error("8888 palette entry not passed through");
    chk_half_rate: assert property (accept && half_rate |=> !IN_READY ##1 IN_READY)
        else $error("half-rate throttle wrong");
    chk_full_rate: assert property (!half_rate |=> IN_READY)
        else $error("ready dropped outside half-rate mode");
    // Bump azimuth codes below the top code pass through unchanged, and each narrow palette form is spread.
    chk_bump_linear: assert property (a_valid_q && a_fmt_q == FMT_BUMP && a_data_q[7:0] != 8'hFF
        |=> OUT_AZIM == {1'b0, $past(a_data_q[7:0])})
        else $error("bump azimuth code not linear");
    chk_pal1555_fields: assert property (a_valid_q && palfmt_q == PAL_1555 &&
        (a_fmt_q == FMT_FOUR_BIT_INDEX || a_fmt_q == FMT_EIGHT_BIT_INDEX) |=>
        OUT_ARGB[23:19] == $past(pal.rd_data[14:10]) && OUT_ARGB[31] == $past(pal.rd_data[15]))
        else $error("1555 palette entry fields misplaced");
    chk_pal565_opaque: assert property (a_valid_q && palfmt_q == PAL_565 &&
        (a_fmt_q == FMT_FOUR_BIT_INDEX || a_fmt_q == FMT_EIGHT_BIT_INDEX) |=>
        OUT_ARGB[31:24] == 8'hFF && OUT_ARGB[15:10] == $past(pal.rd_data[10:5]))
        else $error("565 palette entry not opaque or green misplaced");
    chk_pal4444_fields: assert property (a_valid_q && palfmt_q == PAL_4444 &&
        (a_fmt_q == FMT_FOUR_BIT_INDEX || a_fmt_q == FMT_EIGHT_BIT_INDEX) |=>
        OUT_ARGB[31:28] == $past(pal.rd_data[15:12]) && OUT_ARGB[3:0] == $past(pal.rd_data[3:0]))
        else $error("4444 palette entry fields misplaced");

    cov_yuv_pair: cover property (OUT_VALID && OUT_PAIR);
    cov_bump: cover property (OUT_VALID && OUT_BUMP && OUT_AZIM == 9'h100);
    cov_palette: cover property (accept && in_fmt == FMT_EIGHT_BIT_INDEX ##2 OUT_VALID);
    cov_half_rate: cover property (accept && half_rate ##2 accept);
endmodule
`default_nettype wire

//--- test/texel_fetch_model.sv
// Purpose: Fetch side that offers texels to the decoder.
// Assumes: A push starts just after a rising edge.
// Notes:   Released lines show the inverse of the last value.
`default_nettype none
module texel_fetch_model (
    input  wire logic        clk,
    input  wire logic        ready,
    output logic             valid,
    output logic      [31:0] ctrl,
    output logic      [31:0] data
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle lines at time zero.
    initial begin
        valid = 1'b0;
        ctrl  = 32'h0000_0000;
        data  = 32'h0000_0000;
    end
    // Holds the offer until the edge that takes it, so nothing moves early.
    task automatic push(input logic [31:0] c, input logic [31:0] d, output bit ok);
        logic t;
        ok = 1'b0;
        valid <= 1'b1;
        ctrl  <= c;
        data  <= d;
        for (int n = 0; n < 40 && !ok; n++) begin
            #1;
            t = ready;
            @(posedge clk);
            ok = (t === 1'b1);
        end
        valid <= 1'b0;
        ctrl  <= ~c;
        data  <= ~d;
    endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Purpose: Self-checking bench for the texel decoder.
// Assumes: Fetch model offers texels; bench drives the register bus.
// Notes:   Expected colors are rebuilt from the field layouts.
`include "texel_params.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import texel_pkg::*;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic        CLOCK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic        IN_VALID, IN_READY, OUT_VALID, OUT_PAIR, OUT_BUMP;
    logic [12:0] PADDR;
    logic [31:0] PWDATA, PRDATA, IN_CTRL, IN_DATA, OUT_ARGB, OUT_ARGB_RIGHT;
    logic [8:0]  OUT_ELEV, OUT_AZIM;
    int          n_fail, checks_done, n_out;
    pix_fmt_t    pk[3] = '{FMT_FOUR_BIT_INDEX, FMT_EIGHT_BIT_INDEX, FMT_EIGHT_BIT_INDEX};
    logic [5:0]  ps[3] = '{6'h2A, 6'h2A, 6'h3F};
    logic [7:0]  pt[3] = '{8'hF5, 8'h5C, 8'hFF};
    logic [31:0] pv[3] = '{32'hC3A5_9E37, 32'h5A0F_71C8, 32'h817E_0FF0};
    logic [31:0] yd[3] = '{32'hF0FF_1000, 32'h3480_7A2C, 32'h5C80_A380};
    logic [15:0] bd[3] = '{16'hFF80, 16'h01FF, 16'h3C00};
    texel_format_decoder dut (
        .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_CTRL(IN_CTRL), .IN_DATA(IN_DATA),
        .OUT_VALID(OUT_VALID), .OUT_ARGB(OUT_ARGB), .OUT_ARGB_RIGHT(OUT_ARGB_RIGHT),
        .OUT_PAIR(OUT_PAIR), .OUT_BUMP(OUT_BUMP), .OUT_ELEV(OUT_ELEV), .OUT_AZIM(OUT_AZIM)
    );
    texel_fetch_model fetch (
        .clk(CLOCK), .ready(IN_READY), .valid(IN_VALID), .ctrl(IN_CTRL), .data(IN_DATA)
    );
    // Free-running 10 MHz clock.
    initial begin
        CLOCK = 1'b0;
        forever #50 CLOCK = ~CLOCK;
    end
    // ****************************************
    // Tasks and reference functions
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // One bus transfer; data is taken in the cycle that ends with ready high.
    task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        logic t;
        @(posedge CLOCK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= wd;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        t = 1'b0;
        for (int n = 0; n < 20 && !t; n++) begin
            #1;
            t  = (PREADY === 1'b1);
            rd = PRDATA;
            er = PSLVERR;
            @(posedge CLOCK);
        end
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        if (!t) begin
            chk("bus answer", 32'h1, 32'h0);
            print_verdict();
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdchk(input string nm, input logic [12:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(nm, x, r);
        chk("bus error", {31'h0, xe}, {31'h0, e});
    endtask
    // Offers one texel and checks the pulse that stands after the edge following the take.
    task automatic send(input pix_fmt_t f, input logic [5:0] s, input logic [31:0] d, input bit half);
        bit ok;
        @(posedge CLOCK);
        fetch.push({2'h0, f, s, 21'h00_0000}, d, ok);
        if (!ok) begin
            chk("texel taken", 32'h1, 32'h0);
            print_verdict();
        end
        #1;
        if (half) chk("ready after take", 32'h0, {31'h0, IN_READY});
        @(posedge CLOCK);
        #1;
        chk("output pulse", 32'h1, {31'h0, OUT_VALID});
        n_out++;
    endtask
    function automatic logic [31:0] argb(input logic [1:0] f, input logic [31:0] w);
        case (f)
            2'h0: return {{8{w[15]}}, w[14:10], w[14:12], w[9:5], w[9:7], w[4:0], w[4:2]};
            2'h1: return {8'hFF, w[15:11], w[15:13], w[10:5], w[10:9], w[4:0], w[4:2]};
            2'h2: return {{2{w[15:12]}}, {2{w[11:8]}}, {2{w[7:4]}}, {2{w[3:0]}}};
            default: return w;
        endcase
    endfunction
    function automatic logic [31:0] yuv(input int y, input int u, input int v);
        int c[3];
        c[0] = y + ((11 * (v - 128)) >>> 3);
        c[1] = y - ((11 * (u - 128)) >>> 5) - ((11 * (v - 128)) >>> 4);
        c[2] = y + ((55 * (u - 128)) >>> 5);
        for (int i = 0; i < 3; i++) begin
            c[i] = c[i] < 0 ? 0 : (c[i] > 255 ? 255 : c[i]);
        end
        return {8'hFF, c[0][7:0], c[1][7:0], c[2][7:0]};
    endfunction
    function automatic logic [31:0] bexp(input logic [7:0] c);
        return (c == 8'hFF) ? 32'h100 : {24'h0, c};
    endfunction
    // Main sequence: reset, registers, every texel form, every palette form.
    initial begin
        RST_N   = 1'b0;
        PSEL    = 1'b0;
        PENABLE = 1'b0;
        PWRITE  = 1'b0;
        PADDR   = 13'h0000;
        PWDATA  = 32'h0000_0000;
        repeat (8) @(posedge CLOCK);
        RST_N <= 1'b1;
        repeat (2) @(posedge CLOCK);
        rdchk("format reset", `OFS_PALFMT, 32'h0, 1'b0);
        rdchk("filter reset", `OFS_FILTER, 32'h0, 1'b0);
        rdchk("unmapped", 13'h000C, 32'h0, 1'b1);
        for (int f = 0; f < 3; f++) begin
            send(pix_fmt_t'(f), 6'h00, 32'h7E31_B5E9, 1'b0);
            chk("rgb texel", argb(2'(f), 32'h0000_B5E9), OUT_ARGB);
            send(pix_fmt_t'(f), 6'h00, 32'h0000_4A16, 1'b0);
            chk("rgb texel", argb(2'(f), 32'h0000_4A16), OUT_ARGB);
        end
        for (int k = 0; k < 3; k++) begin
            send(FMT_YUV, 6'h00, yd[k], 1'b0);
            chk("yuv left", yuv(yd[k][15:8], yd[k][7:0], yd[k][23:16]), OUT_ARGB);
            chk("yuv right", yuv(yd[k][31:24], yd[k][7:0], yd[k][23:16]), OUT_ARGB_RIGHT);
            chk("yuv pair", 32'h1, {31'h0, OUT_PAIR});
            send(FMT_BUMP, 6'h00, {16'h0, bd[k]}, 1'b0);
            chk("elevation", bexp(bd[k][15:8]), {23'h0, OUT_ELEV});
            chk("azimuth", bexp(bd[k][7:0]), {23'h0, OUT_AZIM});
            chk("bump flag", 32'h1, {31'h0, OUT_BUMP});
            chk("bump pair clear", 32'h0, {31'h0, OUT_PAIR});
        end
        for (int k = 0; k < 3; k++) begin
            if (pk[k] == FMT_FOUR_BIT_INDEX) wr({1'b1, ps[k], pt[k][3:0], 2'b00}, pv[k]);
            else wr({1'b1, ps[k][5:4], pt[k], 2'b00}, pv[k]);
        end
        for (int f = 0; f < 4; f++) begin
            wr(`OFS_PALFMT, 32'(f));
            wr(`OFS_FILTER, {31'h0, f == 3});
            for (int k = 0; k < 3; k++) begin
                send(pk[k], ps[k], {24'h0, pt[k]}, f == 3);
                chk("palette color", argb(2'(f), pv[k]), OUT_ARGB);
            end
        end
        rdchk("item count", `OFS_COUNT, 32'(n_out), 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
